// [logic/cph_pkg.sv]
// Shared constants for the coprocessor pipeline handshake port
package cph_pkg;

    // ------------------------------------------------------------
    // Handshake encoding
    // ------------------------------------------------------------
    localparam logic [1:0] HS_ABSENT = 2'h2;
    localparam logic [1:0] HS_WAIT = 2'h0;
    localparam logic [1:0] HS_GO = 2'h1;
    localparam logic [1:0] HS_LAST = 2'h3;

    // ------------------------------------------------------------
    // Reset values and address word step
    // ------------------------------------------------------------
    localparam logic [31:0] INSTR_RESET = 32'h0000_0000;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;

    // ------------------------------------------------------------
    // Execute sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CPH_IDLE = 2'b00,
        CPH_FIRST = 2'b01,
        CPH_BUSY = 2'b10,
        CPH_XFER = 2'b11
    } cph_state_e;

endpackage : cph_pkg

// [logic/cph_port.sv]
// Core-side coprocessor pipeline handshake port
// Behaviour
// (RL1) Copro pipeline runs one cycle behind core
// (RL2) Copro holds state when clock enable low
// (RL3) Fetched instruction presented by next enabled edge
// (RL4) Copro shifts pipeline on each enabled fetch
// (RL5) Fetch request is registered instruction request
// (RL6) Pass high for passed coprocessor execute instruction
// (RL7) Pass held while busy-waiting; interrupt drops it
// (RL8) Late cancel after first execute, on abort
// (RL9) Sample decode or execute handshake appropriately
// (RL10) Handshake codes: absent, wait, go, last
// (RL11) Absent response takes undefined instruction trap; an absent execute response in CPH_XFER returns to CPH_IDLE without trap
// (RL12) Wait stalls until change or interrupt; a wait execute response in CPH_XFER returns to CPH_IDLE without stall
// (RL13) Copro commits only on pass with go/last
// (RL14) Go executes now, needs another cycle
// (RL15) Copro sets word count via go/last
// (RL16) Load/store execute drives address, data request
// (RL17) Single word: waits then last
// (RL18) No coprocessor ties handshakes to absent
// (RL19) Multiple coprocessors merge with and/or
// (RL20) Late cancel leaves copro state unchanged
// (RL21) Read data sampled, register written next cycle
// (RL22) Unimplemented instructions answered absent
`timescale 1ns/100ps
`default_nettype none
module cph_port (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic copro_clock_enable,
    input wire logic instr_mem_request_n,
    input wire logic [31:0] fetched_instr,
    input wire logic ex_is_copro,
    input wire logic ex_cond_pass,
    input wire logic ex_is_load_store,
    input wire logic [31:0] ex_address,
    input wire logic prev_data_abort,
    input wire logic interrupt_req,
    input wire logic mem_stage_is_read,
    input wire logic [1:0] decode_handshake,
    input wire logic [1:0] execute_handshake,
    input wire logic [31:0] copro_read_data,
    output logic copro_fetch_request_n,
    output logic [31:0] copro_instruction_bus,
    output logic condition_passed,
    output logic late_cancel,
    output logic data_mem_request_n,
    output logic [31:0] data_address,
    output logic undef_trap,
    output logic core_stall,
    output logic reg_write_en,
    output logic [31:0] reg_write_data
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_reg;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    wire logic rst_n = rst_sync_reg;

    // (RL10) Go and last both let work proceed
    function automatic logic hs_proceeds(input logic [1:0] hs);
        hs_proceeds = (hs == cph_pkg::HS_GO) || (hs == cph_pkg::HS_LAST);
    endfunction : hs_proceeds

    // ------------------------------------------------------------
    // Fetch side
    // ------------------------------------------------------------
    logic fetch_req_n_reg;
    logic fetch_req_n_next;
    logic [31:0] instr_reg;
    logic [31:0] instr_next;
    logic fetch_pending_reg;
    logic fetch_pending_next;

    always_comb begin
        fetch_req_n_next = fetch_req_n_reg;
        instr_next = instr_reg;
        fetch_pending_next = fetch_pending_reg;
        // (RL5) Registered fetch request
        fetch_req_n_next = instr_mem_request_n;
        // (RL3) Present fetched word
        if (fetch_pending_reg) begin
            instr_next = fetched_instr;
        end
        // (RL1) Advance only on enabled fetch
        fetch_pending_next = !fetch_req_n_reg;
    end

    // ------------------------------------------------------------
    // Execute sequencer
    // ------------------------------------------------------------
    cph_pkg::cph_state_e state_reg;
    cph_pkg::cph_state_e state_next;
    logic pass_reg;
    logic pass_next;
    logic cancel_reg;
    logic cancel_next;
    logic dreq_n_reg;
    logic dreq_n_next;
    logic [31:0] addr_reg;
    logic [31:0] addr_next;
    logic trap_reg;
    logic trap_next;
    logic stall_reg;
    logic stall_next;
    logic ls_reg;
    logic ls_next;
    logic rd_pend_reg;
    logic rd_pend_next;
    logic wr_en_reg;
    logic wr_en_next;
    logic [31:0] wr_data_reg;
    logic [31:0] wr_data_next;
    logic first_reg;
    logic first_next;

    always_comb begin
        state_next = state_reg;
        pass_next = 1'b0;
        cancel_next = 1'b0;
        dreq_n_next = 1'b1;
        addr_next = addr_reg;
        trap_next = 1'b0;
        stall_next = 1'b0;
        ls_next = ls_reg;
        rd_pend_next = 1'b0;
        wr_en_next = 1'b0;
        wr_data_next = wr_data_reg;
        first_next = 1'b0;
        unique case (state_reg)
            cph_pkg::CPH_IDLE: begin
                // (RL9) Decode handshake on entry
                if (ex_is_copro && ex_cond_pass) begin
                    // (RL6) Pass for passed copro
                    pass_next = 1'b1;
                    ls_next = ex_is_load_store;
                    state_next = cph_pkg::CPH_FIRST;
                    unique case (decode_handshake)
                        // (RL11) Absent traps
                        cph_pkg::HS_ABSENT: begin
                            trap_next = 1'b1;
                            pass_next = 1'b0;
                            state_next = cph_pkg::CPH_IDLE;
                        end
                        // (RL12) Busy-wait entry
                        cph_pkg::HS_WAIT: begin
                            stall_next = 1'b1;
                            state_next = cph_pkg::CPH_BUSY;
                        end
                        // (RL14) Go needs another cycle
                        cph_pkg::HS_GO: begin
                            stall_next = 1'b1;
                            state_next = cph_pkg::CPH_XFER;
                        end
                        cph_pkg::HS_LAST: begin
                            state_next = ex_is_load_store ? cph_pkg::CPH_XFER
                                                          : cph_pkg::CPH_FIRST;
                        end
                    endcase
                    // (RL16) Load/store address and request
                    if (ex_is_load_store && !trap_next) begin
                        dreq_n_next = 1'b0;
                        addr_next = ex_address;
                    end
                    // (RL21) Capture read data
                    rd_pend_next = mem_stage_is_read && !trap_next;
                    first_next = !trap_next;
                end
            end
            cph_pkg::CPH_FIRST: begin
                state_next = cph_pkg::CPH_IDLE;
            end
            cph_pkg::CPH_BUSY: begin
                // (RL7) Interrupt abandons busy-wait
                if (interrupt_req) begin
                    state_next = cph_pkg::CPH_IDLE;
                    cancel_next = 1'b1;
                end else begin
                    pass_next = 1'b1;
                    stall_next = 1'b1;
                    // (RL12) Leave wait on change
                    unique case (execute_handshake)
                        cph_pkg::HS_ABSENT: begin
                            trap_next = 1'b1;
                            pass_next = 1'b0;
                            stall_next = 1'b0;
                            state_next = cph_pkg::CPH_IDLE;
                        end
                        cph_pkg::HS_WAIT: state_next = cph_pkg::CPH_BUSY;
                        cph_pkg::HS_GO: state_next = cph_pkg::CPH_XFER;
                        cph_pkg::HS_LAST: begin
                            stall_next = ls_reg;
                            state_next = ls_reg ? cph_pkg::CPH_XFER
                                                : cph_pkg::CPH_IDLE;
                        end
                    endcase
                end
            end
            cph_pkg::CPH_XFER: begin
                // (RL9) Execute handshake for more cycles
                pass_next = 1'b1;
                if (ls_reg) begin
                    dreq_n_next = 1'b0;
                    addr_next = addr_reg + cph_pkg::WORD_STEP;
                end
                if (hs_proceeds(execute_handshake) &&
                        execute_handshake == cph_pkg::HS_GO) begin
                    stall_next = 1'b1;
                end else begin
                    state_next = cph_pkg::CPH_IDLE;
                end
            end
        endcase
        // (RL8) Late cancel after first execute
        if (first_reg && prev_data_abort) begin
            cancel_next = 1'b1;
        end
        // (RL21) Write register next cycle
        if (rd_pend_reg) begin
            wr_en_next = 1'b1;
            wr_data_next = copro_read_data;
        end
    end

    // ------------------------------------------------------------
    // Registers, frozen while clock enable low
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_req_n_reg <= 1'b1;
            instr_reg <= cph_pkg::INSTR_RESET;
            fetch_pending_reg <= 1'b0;
            state_reg <= cph_pkg::CPH_IDLE;
            pass_reg <= 1'b0;
            cancel_reg <= 1'b0;
            dreq_n_reg <= 1'b1;
            addr_reg <= cph_pkg::ADDR_RESET;
            trap_reg <= 1'b0;
            stall_reg <= 1'b0;
            ls_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            wr_en_reg <= 1'b0;
            wr_data_reg <= cph_pkg::INSTR_RESET;
            first_reg <= 1'b0;
        // (RL2) Hold on disabled edge
        end else if (copro_clock_enable) begin
            fetch_req_n_reg <= fetch_req_n_next;
            instr_reg <= instr_next;
            fetch_pending_reg <= fetch_pending_next;
            state_reg <= state_next;
            pass_reg <= pass_next;
            cancel_reg <= cancel_next;
            dreq_n_reg <= dreq_n_next;
            addr_reg <= addr_next;
            trap_reg <= trap_next;
            stall_reg <= stall_next;
            ls_reg <= ls_next;
            rd_pend_reg <= rd_pend_next;
            wr_en_reg <= wr_en_next;
            wr_data_reg <= wr_data_next;
            first_reg <= first_next;
        end
    end

    assign copro_fetch_request_n = fetch_req_n_reg;
    assign copro_instruction_bus = instr_reg;
    assign condition_passed = pass_reg;
    assign late_cancel = cancel_reg;
    assign data_mem_request_n = dreq_n_reg;
    assign data_address = addr_reg;
    assign undef_trap = trap_reg;
    assign core_stall = stall_reg;
    assign reg_write_en = wr_en_reg;
    assign reg_write_data = wr_data_reg;

endmodule : cph_port
`default_nettype wire

// [test/cph_port_assertions.sv]
// Concurrent checks on the handshake port's outputs
`timescale 1ns/100ps
`default_nettype none
module cph_port_assertions (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic copro_clock_enable,
    input wire logic instr_mem_request_n,
    input wire logic ex_is_copro,
    input wire logic ex_cond_pass,
    input wire logic prev_data_abort,
    input wire logic interrupt_req,
    input wire logic [1:0] decode_handshake,
    input wire logic [1:0] execute_handshake,
    input wire logic copro_fetch_request_n,
    input wire logic [31:0] copro_instruction_bus,
    input wire logic condition_passed,
    input wire logic late_cancel,
    input wire logic undef_trap,
    input wire logic core_stall
);
    // ------------------------------------------------------------
    // Edges since reset release
    // ------------------------------------------------------------
    logic [1:0] up_reg;
    logic [1:0] up_next;
    logic up;
    logic act;
    logic idle;
    assign up_next = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
    assign up = (up_reg == 2'h3);
    assign act = up && copro_clock_enable;
    assign idle = !condition_passed && !core_stall;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            up_reg <= 2'h0;
        end else begin
            up_reg <= up_next;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence s_issue;
        act && idle && ex_is_copro && ex_cond_pass;
    endsequence
    sequence s_busy;
        act && core_stall && condition_passed;
    endsequence
    a_fetch_req_copy: assert property (act |=> copro_fetch_request_n == $past(instr_mem_request_n))
        else $error("fetch request not a copy");
    a_hold_when_off: assert property (up && !copro_clock_enable |=> $stable(copro_instruction_bus)
        && $stable(condition_passed) && $stable(copro_fetch_request_n))
        else $error("outputs moved while enable low");
    a_issue_pass: assert property (s_issue ##0 decode_handshake != cph_pkg::HS_ABSENT
        |=> condition_passed)
        else $error("pass missing on issue");
    a_absent_trap: assert property (s_issue ##0 decode_handshake == cph_pkg::HS_ABSENT
        |=> undef_trap)
        else $error("absent without trap");
    a_refuse_other: assert property (act && idle && !(ex_is_copro && ex_cond_pass)
        |=> !condition_passed && !undef_trap)
        else $error("pass or trap for no instruction");
    a_cancel_window: assert property (s_issue ##0 decode_handshake == cph_pkg::HS_LAST ##1 act
        |=> late_cancel == $past(prev_data_abort))
        else $error("late cancel wrong after first execute");
    a_cancel_after: assert property (up && $rose(late_cancel) |-> $past(condition_passed))
        else $error("late cancel outside execute");
    a_wait_stall: assert property (s_issue ##0 decode_handshake == cph_pkg::HS_WAIT
        |=> core_stall && condition_passed)
        else $error("wait did not stall");
    a_irq_abandon: assert property (s_busy ##0 execute_handshake == cph_pkg::HS_WAIT
        && interrupt_req |=> !condition_passed)
        else $error("interrupt kept pass high");
    a_wait_absent: assert property (s_busy ##0 execute_handshake == cph_pkg::HS_ABSENT
        |=> undef_trap)
        else $error("absent after wait without trap");
endmodule : cph_port_assertions
`default_nettype wire

// [test/cph_copro_model.sv]
// Pipeline follower model of an attached coprocessor
`timescale 1ns/100ps
`default_nettype none
module cph_copro_model (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic copro_clock_enable,
    input wire logic copro_fetch_request_n,
    input wire logic [31:0] copro_instruction_bus,
    input wire logic condition_passed,
    input wire logic late_cancel,
    input wire logic [1:0] dec_resp,
    input wire logic [1:0] ex_resp,
    output logic [1:0] decode_handshake,
    output logic [1:0] execute_handshake,
    output logic [7:0] commit_count
);
    logic [31:0] dec_reg;
    logic [31:0] ex_reg;
    logic pend_reg;
    localparam logic [1:0] OTHER_RESP = cph_pkg::HS_ABSENT;
    assign decode_handshake = {dec_resp[1] & OTHER_RESP[1], dec_resp[0] | OTHER_RESP[0]};
    assign execute_handshake = {ex_resp[1] & OTHER_RESP[1], ex_resp[0] | OTHER_RESP[0]};
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dec_reg <= 32'h0000_0000;
            ex_reg <= 32'h0000_0000;
            pend_reg <= 1'h0;
            commit_count <= 8'h00;
        end else if (copro_clock_enable) begin
            if (!copro_fetch_request_n) begin
                ex_reg <= dec_reg;
                dec_reg <= copro_instruction_bus;
            end
            // Commit needs pass with go or last
            pend_reg <= condition_passed && execute_handshake[0];
            if (pend_reg && !late_cancel) begin
                commit_count <= commit_count + 8'h01;
            end
        end
    end
endmodule : cph_copro_model
`default_nettype wire

// [test/test_coprocessor_pipeline_handshake.sv]
// Self-checking bench for the coprocessor handshake port
`timescale 1ns/100ps
`default_nettype none
module test_coprocessor_pipeline_handshake;
    logic mclk = 1'h0;
    logic resetn = 1'h0;
    logic copro_clock_enable = 1'h1, instr_mem_request_n = 1'h1, ex_is_copro = 1'h0;
    logic ex_cond_pass = 1'h0, ex_is_load_store = 1'h0, prev_data_abort = 1'h0;
    logic interrupt_req = 1'h0, mem_stage_is_read = 1'h0, exp_req = 1'h1;
    logic [31:0] fetched_instr = 32'h0000_0000, ex_address = 32'h0000_0000;
    logic [31:0] copro_read_data = 32'h0000_0000;
    logic [1:0] dec_resp = cph_pkg::HS_ABSENT, ex_resp = cph_pkg::HS_ABSENT;
    logic [1:0] decode_handshake, execute_handshake;
    logic [7:0] commit_count;
    logic copro_fetch_request_n, condition_passed, late_cancel, data_mem_request_n;
    logic undef_trap, core_stall, reg_write_en;
    logic [31:0] copro_instruction_bus, data_address, reg_write_data;
    int mismatches = 0;
    int cmp_count = 0;
    always #5 mclk = ~mclk;
    cph_port DUT (.*);
    cph_copro_model partner (.*);
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_bit
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic step(input int n);
        repeat (n) @(negedge mclk);
        copro_read_data = $urandom;
        ex_address = $urandom;
        mem_stage_is_read = 1'($urandom);
    endtask : step
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    task automatic issue(input logic [1:0] code, input logic flag);
        logic [31:0] adr;
        logic rd;
        adr = ex_address;
        rd = mem_stage_is_read;
        ex_is_copro = 1'h1;
        ex_cond_pass = 1'h1;
        ex_is_load_store = 1'($urandom);
        dec_resp = code;
        ex_resp = (code == cph_pkg::HS_GO) ? cph_pkg::HS_LAST : cph_pkg::HS_ABSENT;
        if (code == cph_pkg::HS_WAIT) begin
            ex_resp = cph_pkg::HS_WAIT;
        end
        step(1);
        ex_is_copro = 1'h0;
        dec_resp = cph_pkg::HS_ABSENT;
        prev_data_abort = flag;
        cmp_bit(condition_passed, code != cph_pkg::HS_ABSENT);
        cmp_bit(undef_trap, code == cph_pkg::HS_ABSENT);
        cmp_bit(core_stall, code == cph_pkg::HS_WAIT || code == cph_pkg::HS_GO);
        cmp_bit(data_mem_request_n, !(ex_is_load_store && code != cph_pkg::HS_ABSENT));
        if (ex_is_load_store && code != cph_pkg::HS_ABSENT) begin
            cmp_word(data_address, adr);
        end
        if (code == cph_pkg::HS_WAIT) begin
            step(1);
            cmp_bit(condition_passed, 1'h1);
            interrupt_req = flag;
            ex_resp = flag ? cph_pkg::HS_WAIT : cph_pkg::HS_ABSENT;
            step(1);
            interrupt_req = 1'h0;
            cmp_bit(flag ? condition_passed : undef_trap, !flag);
        end
        step(1);
        if (code != cph_pkg::HS_WAIT) begin
            cmp_bit(reg_write_en, rd && code != cph_pkg::HS_ABSENT);
        end
        if (code == cph_pkg::HS_LAST) begin
            cmp_bit(late_cancel, flag);
        end
        prev_data_abort = 1'h0;
        step(1);
        ex_resp = cph_pkg::HS_ABSENT;
        step(3);
    endtask : issue
    initial begin
        #100000;
        mismatches++;
        complete_run();
    end
    initial begin
        void'($urandom(42498));
        step(2);
        resetn = 1'h1;
        step(3);
        for (int i = 0; i < 40; i++) begin
            copro_clock_enable = 1'($urandom);
            instr_mem_request_n = 1'($urandom);
            fetched_instr = $urandom;
            if (copro_clock_enable) begin
                exp_req = instr_mem_request_n;
            end
            step(1);
            cmp_bit(copro_fetch_request_n, exp_req);
        end
        copro_clock_enable = 1'h1;
        $display("Test fetch request done");
        ex_is_copro = 1'h1;
        dec_resp = cph_pkg::HS_LAST;
        step(1);
        ex_is_copro = 1'h0;
        cmp_bit(condition_passed, 1'h0);
        $display("Test failed condition done");
        for (int c = 0; c < 8; c++) begin
            issue(2'(c >> 1), c[0]);
        end
        issue(cph_pkg::HS_LAST, 1'($urandom));
        $display("Test handshake codes done");
        complete_run();
    end
endmodule : test_coprocessor_pipeline_handshake
bind cph_port cph_port_assertions u_chk (.*);
`default_nettype wire
